// *** core/ivr_consts.vh ***
// constants for the interrupt vector responder
`ifndef IVR_CONSTS_VH
`define IVR_CONSTS_VH
`define IVR_CALL_OPCODE 8'hcd
`define IVR_CLK_HZ 40000000
// axi4-lite register byte offsets
`define IVR_OFF_CTRL 8'h00
`define IVR_OFF_BASE 8'h04
`define IVR_OFF_STAT 8'h08
`define IVR_OFF_ISR 8'h0c
`define IVR_OFF_IRQ_STAT 8'h10
`define IVR_OFF_IRQ_EN 8'h14
`define IVR_OFF_IRQ_CLR 8'h18
`define IVR_OFF_ISR_CLR 8'h1c
// ctrl fields
`define IVR_CTRL_TYPE_BIT 0
`define IVR_CTRL_INT8_BIT 1
`define IVR_CTRL_MASK_LSB 8
`define IVR_CTRL_RST 32'h0000_0000
// vector field positions
`define IVR_VEC4_BASE_LSB 5
`define IVR_VEC8_BASE_LSB 6
`define IVR_TYPE_BASE_LSB 3
// interrupt status bits
`define IVR_EV_ACK_DONE 0
`define IVR_EV_PROTO_ERR 1
`define IVR_EV_W 2
`define IVR_RESP_OKAY 2'b00
`define IVR_RESP_SLVERR 2'b10
`endif

// *** core/ivr_responder.v ***
// interrupt acknowledge responder with axi4-lite control registers
// Notes on behaviour
// - call mode: three acknowledge pulses return call opcode then 16-bit address
// - call mode: first pulse drives opcode cd hex on data bus
// - first pulse of either mode resolves priority and freezes the request latches
// - call mode: second pulse drives low byte of vector address
// - call mode: third pulse drives high address byte a15..a8 from base
// - all eight vectors derive from one base, spaced 4 or 8 bytes
// - 4-byte spacing: a4..a2 level number, a1..a0 zero, a15..a5 base
// - 8-byte spacing: a5..a3 level number, a2..a0 zero, a15..a6 base
// - type mode: two acknowledge pulses return a single vector byte
// - type mode: first pulse is internal setup only, bus not driven
// - type mode: second pulse drives vector byte, top five bits from type base
// - type mode: low three bits carry acknowledged level number
// - mode is programmed; sequence length and bytes follow it
// - request latches freeze while an acknowledge sequence runs
// - at sequence end the acknowledged level's in-service bit is set
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ivr_consts.vh"
module ivr_responder #(
  parameter NUM_LEVELS = 8
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // interrupt sources and processor pins
  input wire [7:0] request_inputs,
  input wire irq_ack_strobe_n,
  output reg int_req_q,
  output reg [7:0] data_out_q,
  output reg data_oe_q,
  // system interrupt
  output reg irq_q,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_IDLE = 2'd0;
  localparam ST_P1 = 2'd1;
  localparam ST_P2 = 2'd2;
  localparam ST_P3 = 2'd3;

  // pin synchronisers: three stages, change counts when stages two and three agree
  reg [2:0] ack_s_q;
  reg ack_low_q;
  // requests are levels, so each bit is filtered on its own
  reg [7:0] req_s1_q;
  reg [7:0] req_s2_q;
  reg [7:0] req_s3_q;
  reg [7:0] req_filt_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s_q <= 3'h7;
      ack_low_q <= 1'b0;
      req_s1_q <= 8'h00;
      req_s2_q <= 8'h00;
      req_s3_q <= 8'h00;
      req_filt_q <= 8'h00;
    end else begin
      ack_s_q <= {ack_s_q[1:0], irq_ack_strobe_n};
      if (ack_s_q[1] == ack_s_q[2]) begin
        ack_low_q <= ~ack_s_q[2];
      end
      req_s1_q <= request_inputs;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      req_filt_q <= (req_s2_q & req_s3_q) | (req_filt_q & (req_s2_q | req_s3_q));
    end
  end

  // control registers
  reg [31:0] ctrl_q;
  reg [15:0] base_q;
  reg [7:0] isr_q;
  reg [7:0] req_latch_q;
  reg [`IVR_EV_W-1:0] irq_stat_q;
  reg [`IVR_EV_W-1:0] irq_en_q;
  wire type_mode = ctrl_q[`IVR_CTRL_TYPE_BIT];
  wire int8 = ctrl_q[`IVR_CTRL_INT8_BIT];
  wire [7:0] mask = ctrl_q[`IVR_CTRL_MASK_LSB+7:`IVR_CTRL_MASK_LSB];

  // acknowledge sequencer
  reg [1:0] state_q;
  reg [2:0] level_q;
  reg ack_low_d1_q;
  wire ack_fall = ack_low_q & ~ack_low_d1_q;
  wire ack_rise = ~ack_low_q & ack_low_d1_q;
  wire [7:0] pend = req_latch_q & ~mask;

  // fixed priority, level 0 highest; nesting blocks same or lower levels
  reg [2:0] win_lvl;
  reg win_ok;
  integer i;
  always @* begin
    win_lvl = 3'd0;
    win_ok = 1'b0;
    for (i = NUM_LEVELS - 1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        win_lvl = i[2:0];
        win_ok = 1'b1;
      end
    end
    for (i = 0; i < NUM_LEVELS; i = i + 1) begin
      if (isr_q[i] && i[2:0] <= win_lvl) begin
        win_ok = 1'b0;
      end
    end
  end


  // level number sits just above the zero bits; the base supplies the rest
  wire [15:0] vec_addr4 = {base_q[15:`IVR_VEC4_BASE_LSB], level_q, 2'b00};
  wire [15:0] vec_addr8 = {base_q[15:`IVR_VEC8_BASE_LSB], level_q, 3'b000};
  wire [15:0] vec_addr = int8 ? vec_addr8 : vec_addr4;
  wire [7:0] type_byte = {base_q[7:`IVR_TYPE_BASE_LSB], level_q};
  wire seq_last = (state_q == ST_P3) | (type_mode & (state_q == ST_P2));
  reg ev_done_q;
  reg ev_err_q;
  reg isr_clr_wr;
  reg [7:0] isr_clr_val;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      level_q <= 3'd0;
      ack_low_d1_q <= 1'b0;
      req_latch_q <= 8'h00;
      isr_q <= 8'h00;
      int_req_q <= 1'b0;
      data_out_q <= 8'h00;
      data_oe_q <= 1'b0;
      ev_done_q <= 1'b0;
      ev_err_q <= 1'b0;
    end else begin
      ack_low_d1_q <= ack_low_q;
      ev_done_q <= 1'b0;
      ev_err_q <= 1'b0;
      if (state_q == ST_IDLE) begin
        req_latch_q <= req_filt_q;
        int_req_q <= win_ok;
      end
      if (isr_clr_wr) begin
        isr_q <= isr_q & ~isr_clr_val;
      end
      if (ack_fall) begin
        case (state_q)
          ST_IDLE: begin
            // first pulse: freeze latches and resolve priority; no cascade in this block
            level_q <= win_lvl;
            state_q <= ST_P1;
            // a pulse with no request still runs the sequence; the fault is only flagged
            ev_err_q <= ~int_req_q;
            data_out_q <= `IVR_CALL_OPCODE;
            data_oe_q <= ~type_mode;
          end
          ST_P1: begin
            state_q <= ST_P2;
            data_out_q <= type_mode ? type_byte : vec_addr[7:0];
            data_oe_q <= 1'b1;
          end
          ST_P2: begin
            state_q <= ST_P3;
            data_out_q <= vec_addr[15:8];
            data_oe_q <= 1'b1;
          end
          default: begin
            state_q <= ST_IDLE;
            data_oe_q <= 1'b0;
          end
        endcase
      end else if (ack_rise) begin
        data_oe_q <= 1'b0;
        if (seq_last) begin
          state_q <= ST_IDLE;
          isr_q <= (isr_clr_wr ? isr_q & ~isr_clr_val : isr_q)
                   | (8'h01 << level_q);
          int_req_q <= 1'b0;
          ev_done_q <= 1'b1;
        end
      end
    end
  end

  // axi4-lite slave: address and data taken in either order, one write at a time
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  // status word: captured requests, chosen level, request pin and sequencer state
  wire [31:0] stat_word = {16'h0000, req_latch_q, 1'b0, level_q, int_req_q, 1'b0, state_q};
  // unstrobed bytes land as zero rather than keeping their old value
  wire [31:0] wstrb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  always @* begin
    isr_clr_wr = wr_go && aw_addr_q == `IVR_OFF_ISR_CLR;
    isr_clr_val = w_data_q[7:0];
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IVR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `IVR_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      ctrl_q <= `IVR_CTRL_RST;
      base_q <= 16'h0000;
      irq_stat_q <= {`IVR_EV_W{1'b0}};
      irq_en_q <= {`IVR_EV_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata & wstrb_mask;
      end
      // sticky events; a set in the clear cycle wins
      // events pulse for one cycle; status keeps them until software clears them
      irq_stat_q <= irq_stat_q | {ev_err_q, ev_done_q};
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `IVR_RESP_OKAY;
        // mode only changes between sequences to keep one consistent length
        if (aw_addr_q == `IVR_OFF_CTRL) begin
          if (state_q == ST_IDLE) ctrl_q <= w_data_q;
        end else if (aw_addr_q == `IVR_OFF_BASE) begin
          base_q <= w_data_q[15:0];
        end else if (aw_addr_q == `IVR_OFF_IRQ_EN) begin
          irq_en_q <= w_data_q[`IVR_EV_W-1:0];
        end else if (aw_addr_q == `IVR_OFF_IRQ_CLR) begin
          irq_stat_q <= (irq_stat_q & ~w_data_q[`IVR_EV_W-1:0]) | {ev_err_q, ev_done_q};
        end else if (aw_addr_q != `IVR_OFF_ISR_CLR) begin
          s_axi_bresp <= `IVR_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      irq_q <= |(irq_stat_q & irq_en_q);
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `IVR_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr == `IVR_OFF_CTRL) begin
          s_axi_rdata <= ctrl_q;
        end else if (s_axi_araddr == `IVR_OFF_BASE) begin
          s_axi_rdata <= {16'h0000, base_q};
        end else if (s_axi_araddr == `IVR_OFF_STAT) begin
          s_axi_rdata <= stat_word;
        end else if (s_axi_araddr == `IVR_OFF_ISR) begin
          s_axi_rdata <= {24'h000000, isr_q};
        end else if (s_axi_araddr == `IVR_OFF_IRQ_STAT) begin
          s_axi_rdata <= {{(32-`IVR_EV_W){1'b0}}, irq_stat_q};
        end else if (s_axi_araddr == `IVR_OFF_IRQ_EN) begin
          s_axi_rdata <= {{(32-`IVR_EV_W){1'b0}}, irq_en_q};
        end else if (s_axi_araddr != `IVR_OFF_IRQ_CLR && s_axi_araddr != `IVR_OFF_ISR_CLR) begin
          s_axi_rresp <= `IVR_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ivr_responder
`default_nettype wire

// *** bench/ivr_chk.sv ***
// assertions on the acknowledge pins of the responder
`timescale 1ns/1ps
`default_nettype none
module ivr_chk #(
  parameter NUM_LEVELS = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // processor pins
  input wire logic irq_ack_strobe_n,
  input wire logic int_req_q,
  input wire logic [7:0] data_out_q,
  input wire logic data_oe_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // pulse count; mode is inferred from a drive on pulse one, so no register tap is needed
  logic [1:0] cnt_q;
  logic call_q;
  logic strb_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'd0;
      call_q <= 1'b0;
      strb_q <= 1'b1;
    end else begin
      strb_q <= irq_ack_strobe_n;
      if (!int_req_q && irq_ack_strobe_n) begin
        cnt_q <= 2'd0;
        call_q <= 1'b0;
      end else begin
        if (strb_q && !irq_ack_strobe_n) cnt_q <= cnt_q + 2'd1;
        if (data_oe_q && cnt_q == 2'd1) call_q <= 1'b1;
      end
    end
  end
  sequence s_drive(int n); $rose(data_oe_q) && cnt_q == n; endsequence
  sequence s_last; $rose(irq_ack_strobe_n) && cnt_q == (call_q ? 2'd3 : 2'd2); endsequence
  property p_cause; $rose(data_oe_q) |-> !$past(irq_ack_strobe_n, 3); endproperty
  a_cause: assert property (p_cause) else $error("drive without pulse");
  property p_release; $rose(irq_ack_strobe_n) |-> ##[1:7] !data_oe_q; endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_opcode; s_drive(1) |-> data_out_q == 8'hcd; endproperty
  a_opcode: assert property (p_opcode) else $error("bad first byte");
  property p_hold; data_oe_q && $past(data_oe_q) |-> $stable(data_out_q); endproperty
  a_hold: assert property (p_hold) else $error("byte changed");
  property p_req; $rose(data_oe_q) |-> int_req_q; endproperty
  a_req: assert property (p_req) else $error("drive with no request");
  property p_call_lo; s_drive(2) ##0 call_q |-> data_out_q[1:0] == 2'b00; endproperty
  a_call_lo: assert property (p_call_lo) else $error("low bits set");
  property p_third; s_drive(3) |-> call_q; endproperty
  a_third: assert property (p_third) else $error("third byte in type mode");
  property p_end; s_last |-> ##[1:8] !int_req_q; endproperty
  a_end: assert property (p_end) else $error("request kept");
endmodule // ivr_chk
bind ivr_responder ivr_chk #(.NUM_LEVELS(NUM_LEVELS)) ivr_chk_i (.core_clk(core_clk),
  .rst_n(rst_n), .irq_ack_strobe_n(irq_ack_strobe_n), .int_req_q(int_req_q),
  .data_out_q(data_out_q), .data_oe_q(data_oe_q));
`default_nettype wire

// *** bench/ivr_host.sv ***
// processor model issuing acknowledge pulses
`timescale 1ns/1ps
`default_nettype none
module ivr_host (
  // clock and request
  input wire logic core_clk,
  input wire logic int_req,
  // data bus
  input wire logic [7:0] bus,
  input wire logic bus_oe,
  // acknowledge strobe
  output logic strobe_n
);
  logic [23:0] got;
  logic [2:0] drv;
  logic rel;
  initial strobe_n = 1'b1;
  // w must exceed the answer latency, else the byte is sampled too early
  task automatic ack(input int n, input int w);
    int t;
    t = 0;
    while (!int_req && t < 100) begin
      @(posedge core_clk);
      t++;
    end
    got = 24'h0;
    drv = 3'b000;
    rel = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      strobe_n <= 1'b0;
      repeat (w) @(posedge core_clk);
      got = {got[15:0], bus_oe ? bus : 8'h00};
      drv = {drv[1:0], bus_oe};
      strobe_n <= 1'b1;
      repeat (w) @(posedge core_clk);
      rel = rel | bus_oe;
    end
  endtask
endmodule // ivr_host
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the responder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t got %h exp %h", $time, g, e); end end
module tb;
  logic core_clk, rst_n, int_req, oe, irq, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  wire logic strobe_n;
  logic [7:0] req, dout, awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp, wresp;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  ivr_responder ivr_responder_i (.core_clk(core_clk), .rst_n(rst_n), .request_inputs(req),
    .irq_ack_strobe_n(strobe_n), .int_req_q(int_req), .data_out_q(dout), .data_oe_q(oe),
    .irq_q(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));
  ivr_host ivr_host_i (.core_clk(core_clk), .int_req(int_req), .bus(dout), .bus_oe(oe),
    .strobe_n(strobe_n));
  always #12.5 core_clk = ~core_clk;
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      finish_test();
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awa <= a;
    wd <= d;
    {awv, wv, br} <= 3'b111;
    do begin
      @(posedge core_clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    wresp = bresp;
    br <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    @(posedge core_clk);
    ara <= a;
    {arv, rr} <= 2'b11;
    do begin
      @(posedge core_clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    s = rresp;
    rr <= 1'b0;
  endtask
  // one sequence, then the in-service bit is read and cleared
  task automatic run(input logic [15:0] c, input logic [7:0] r, input logic [2:0] lv,
      input int n, input int w);
    logic [31:0] d;
    logic [1:0] s;
    axi_wr(8'h00, {16'h0, c});
    axi_wr(8'h04, 32'h5baf);
    req <= r;
    ivr_host_i.ack(n, w);
    `CHK(int_req, 1'b0)
    axi_rd(8'h0c, d, s);
    `CHK(d[7:0], 8'h01 << lv)
    req <= 8'h00;
    repeat (10) @(posedge core_clk);
    axi_wr(8'h1c, 32'hff);
  endtask
  task automatic t_call(input logic sp, input logic [7:0] r, input logic [2:0] lv);
    logic [7:0] lo;
    lo = sp ? {2'b10, lv, 3'b000} : {3'b101, lv, 2'b00};
    run({sp, 1'b0}, r, lv, 3, 6);
    `CHK(ivr_host_i.got, {8'hcd, lo, 8'h5b})
    `CHK({ivr_host_i.drv, ivr_host_i.rel}, 4'he)
    $display("call test %0d done", lv);
  endtask
  task automatic t_type(input logic [2:0] lv);
    run(2'b01, 8'h80 | (8'h01 << lv), lv, 2, 12);
    `CHK(ivr_host_i.got[15:0], {8'h00, 5'b10101, lv})
    `CHK({ivr_host_i.drv[1:0], ivr_host_i.rel}, 3'b010)
    $display("type test %0d done", lv);
  endtask
  // level 2 masked off, so level 5 must win the resolution
  task automatic t_mask();
    run(16'h0401, 8'h24, 3'd5, 2, 12);
    `CHK(ivr_host_i.got[7:0], {5'b10101, 3'd5})
    $display("mask test done");
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] s;
    axi_wr(8'h18, 32'h3);
    `CHK(wresp, 2'b00)
    axi_wr(8'h14, 32'h1);
    t_type(3'd3);
    `CHK(irq, 1'b1)
    axi_wr(8'h18, 32'h1);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b0)
    axi_wr(8'h14, 32'h0);
    t_type(3'd4);
    axi_rd(8'h10, d, s);
    `CHK({irq, s, d[0]}, 4'b0001)
    axi_rd(8'h40, d, s);
    `CHK({s, d}, {2'b10, 32'h0})
    axi_wr(8'h40, 32'h1);
    `CHK(wresp, 2'b10)
    $display("irq test done");
  endtask
  initial begin
    {core_clk, rst_n, awv, wv, br, arv, rr} = 7'h0;
    {req, awa, ara, wd} = 56'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_call(1'b0, 8'h24, 3'd2);
    t_call(1'b1, 8'h80, 3'd7);
    for (int i = 0; i < 8; i++) t_type(i[2:0]);
    t_mask();
    t_irq();
    finish_test();
  end
endmodule // tb
`default_nettype wire
